// ### hdl/cbs_pkg.sv
// Package and per-cycle step table for the bus cycle sequencer.
// Assumes a single clock; the step table is purely combinational.
`timescale 1ns/10ps

package cbs_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_RETURN_SUB         = 3'h0,
		OP_WAIT_FOR_INTERRUPT = 3'h1,
		OP_MULTIPLY_8X8       = 3'h2,
		OP_INTERRUPT_RETURN   = 3'h3,
		OP_SOFTWARE_INTERRUPT = 3'h4
	} cbs_op_e;

	typedef enum logic [1:0] {
		BASE_OPCODE = 2'h0,
		BASE_STACK  = 2'h1,
		BASE_DUMMY  = 2'h2,
		BASE_VECTOR = 2'h3
	} cbs_base_e;

	typedef enum logic [2:0] {
		BYTE_NONE = 3'h0,
		BYTE_PCL  = 3'h1,
		BYTE_PCH  = 3'h2,
		BYTE_XL   = 3'h3,
		BYTE_XH   = 3'h4,
		BYTE_A    = 3'h5,
		BYTE_B    = 3'h6,
		BYTE_CC   = 3'h7
	} cbs_byte_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01
	} cbs_state_e;

	// ----------------------------------------------------------------
	// Addresses, cycle numbers, lengths, offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_DUMMY      = 16'hffff;
	localparam logic [15:0] ADDR_VECTOR     = 16'hfffa;
	localparam logic [3:0]  CYC_IDLE        = 4'h0;
	localparam logic [3:0]  CYC_FETCH       = 4'h1;
	localparam logic [3:0]  CYC_NEXT        = 4'h2;
	localparam logic [3:0]  CYC_STACK       = 4'h3;
	localparam logic [3:0]  CYC_SOFT_DUMMY  = 4'ha;
	localparam logic [3:0]  CYC_SOFT_VECTOR = 4'hb;
	localparam logic [3:0]  LEN_RETURN_SUB  = 4'h5;
	localparam logic [3:0]  LEN_WAIT        = 4'h9;
	localparam logic [3:0]  LEN_MULTIPLY    = 4'ha;
	localparam logic [3:0]  LEN_INT_RETURN  = 4'ha;
	localparam logic [3:0]  LEN_SOFT_INT    = 4'hc;
	localparam logic [3:0]  OFF_ZERO        = 4'h0;
	localparam logic [3:0]  OFF_NEXT        = 4'h1;
	localparam logic [3:0]  OFF_SOFT_DUMMY  = 4'h9;
	localparam logic [15:0] FRAME_FULL      = 16'h0007;
	localparam logic [15:0] FRAME_RETURN    = 16'h0002;

	// ----------------------------------------------------------------
	// Stack order and instruction length helpers
	// ----------------------------------------------------------------
	function automatic cbs_byte_e push_byte(input logic [3:0] idx);
		unique case (idx)
			4'h0: push_byte = BYTE_PCL;
			4'h1: push_byte = BYTE_PCH;
			4'h2: push_byte = BYTE_XL;
			4'h3: push_byte = BYTE_XH;
			4'h4: push_byte = BYTE_A;
			4'h5: push_byte = BYTE_B;
			4'h6: push_byte = BYTE_CC;
			default: push_byte = BYTE_NONE;
		endcase
	endfunction

	function automatic cbs_byte_e pull_byte(input logic [3:0] idx);
		unique case (idx)
			4'h1: pull_byte = BYTE_CC;
			4'h2: pull_byte = BYTE_B;
			4'h3: pull_byte = BYTE_A;
			4'h4: pull_byte = BYTE_XH;
			4'h5: pull_byte = BYTE_XL;
			4'h6: pull_byte = BYTE_PCH;
			4'h7: pull_byte = BYTE_PCL;
			default: pull_byte = BYTE_NONE;
		endcase
	endfunction

	function automatic logic [3:0] op_length(input cbs_op_e op);
		unique case (op)
			OP_RETURN_SUB:         op_length = LEN_RETURN_SUB;
			OP_WAIT_FOR_INTERRUPT: op_length = LEN_WAIT;
			OP_MULTIPLY_8X8:       op_length = LEN_MULTIPLY;
			OP_INTERRUPT_RETURN:   op_length = LEN_INT_RETURN;
			default:               op_length = LEN_SOFT_INT;
		endcase
	endfunction

endpackage

// Decodes one bus cycle of one instruction into address base, offset,
// direction and which byte is written or captured.
module cbs_step
	import cbs_pkg::*;
(
	// Selection
	input  wire cbs_op_e   op,
	input  wire logic [3:0] cycle,
	// Step
	output cbs_base_e      base,
	output logic [3:0]     off,
	output logic           rw,
	output cbs_byte_e      wsel,
	output cbs_byte_e      rsel,
	output logic           last
);

	always_comb begin
		base = BASE_DUMMY;
		off  = OFF_ZERO;
		rw   = 1'b1;
		wsel = BYTE_NONE;
		rsel = BYTE_NONE;
		last = (cycle == op_length(op));
		if (cycle == CYC_FETCH) begin
			base = BASE_OPCODE;
		end else if (cycle == CYC_NEXT) begin
			base = BASE_OPCODE;
			off  = OFF_NEXT;
		end else if (cycle != CYC_IDLE) begin
			unique case (op)
				OP_RETURN_SUB: begin
					base = BASE_STACK;
					off  = cycle - CYC_STACK;
					rsel = (cycle == LEN_RETURN_SUB) ? BYTE_PCL :
						(cycle == CYC_STACK) ? BYTE_NONE : BYTE_PCH;
				end
				OP_INTERRUPT_RETURN: begin
					base = BASE_STACK;
					off  = cycle - CYC_STACK;
					rsel = pull_byte(cycle - CYC_STACK);
				end
				OP_MULTIPLY_8X8: begin
					base = BASE_DUMMY;
				end
				default: begin
					// Wait and software interrupt share the stacking part
					if (cycle < CYC_SOFT_DUMMY) begin
						base = BASE_STACK;
						off  = CYC_STACK - cycle;
						rw   = 1'b0;
						wsel = push_byte(cycle - CYC_STACK);
					end else if (cycle == CYC_SOFT_DUMMY) begin
						base = BASE_STACK;
						off  = OFF_SOFT_DUMMY;
					end else begin
						base = BASE_VECTOR;
						off  = cycle - CYC_SOFT_VECTOR;
						rsel = (cycle == LEN_SOFT_INT) ? BYTE_PCL : BYTE_PCH;
					end
				end
			endcase
		end
	end

endmodule

// ### hdl/cbs_sequencer.sv
// Bus cycle sequencer for five inherent instructions of an 8-bit core.
// Assumes memory answers reads in the same cycle on the core clock.
//
// Contract
// - Subroutine return: five reads, stack return address.
// - Wait: nine cycles, two reads then writes.
// - Stacking writes descending: PC, X, A, B, CC.
// - Multiply: ten reads, last eight at FFFF.
// - Interrupt return: ten reads pulling CC, B, A.
// - Interrupt return then pulls X and PC.
// - Software interrupt: twelve cycles, dummy read SP-7.
// - Software interrupt fetches handler from FFFA/FFFB.
`timescale 1ns/10ps

module cbs_sequencer
	import cbs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Request
	input  wire logic        start,
	input  wire cbs_op_e     op,
	input  wire logic [15:0] opcode_addr,
	input  wire logic [15:0] stack_ptr,
	input  wire logic [15:0] index_in,
	input  wire logic [7:0]  acc_a_in,
	input  wire logic [7:0]  acc_b_in,
	input  wire logic [7:0]  ccr_in,
	// Memory bus
	output logic [15:0]      addr,
	output logic             rw,
	output logic [7:0]       wr_data,
	output logic             bus_active,
	input  wire logic [7:0]  rd_data,
	// Result
	output logic             busy,
	output logic             done,
	output logic [15:0]      res_pc,
	output logic [15:0]      res_sp,
	output logic [15:0]      res_x,
	output logic [7:0]       res_a,
	output logic [7:0]       res_b,
	output logic [7:0]       res_cc
);

	// ----------------------------------------------------------------
	// Sequencing state
	// ----------------------------------------------------------------
	cbs_state_e  state;
	logic [3:0]  cycle;
	cbs_op_e     op_q;
	logic [15:0] opa_q;
	logic [15:0] sp_q;

	logic        go;
	logic        fin;
	logic [3:0]  next_cycle;
	cbs_op_e     next_op;
	logic [15:0] next_addr;
	logic [15:0] opa_src;

	logic        cur_rw;
	cbs_byte_e   cur_rsel;
	logic        cur_last;

	cbs_base_e   nxt_base;
	logic [3:0]  nxt_off;
	logic        nxt_rw;
	cbs_byte_e   nxt_wsel;

	function automatic logic [15:0] ext(input logic [3:0] o);
		ext = {{12{o[3]}}, o};
	endfunction

	function automatic logic [7:0] stack_byte(input cbs_byte_e s);
		unique case (s)
			BYTE_PCL: stack_byte = res_pc[7:0];
			BYTE_PCH: stack_byte = res_pc[15:8];
			BYTE_XL:  stack_byte = res_x[7:0];
			BYTE_XH:  stack_byte = res_x[15:8];
			BYTE_A:   stack_byte = res_a;
			BYTE_B:   stack_byte = res_b;
			BYTE_CC:  stack_byte = res_cc;
			default:  stack_byte = 8'h00;
		endcase
	endfunction

	// Current cycle decodes capture and end; next cycle feeds the bus
	cbs_step u_cur (
		.op   (op_q),
		.cycle(cycle),
		.base (),
		.off  (),
		.rw   (cur_rw),
		.wsel (),
		.rsel (cur_rsel),
		.last (cur_last)
	);

	cbs_step u_nxt (
		.op   (next_op),
		.cycle(next_cycle),
		.base (nxt_base),
		.off  (nxt_off),
		.rw   (nxt_rw),
		.wsel (nxt_wsel),
		.rsel (),
		.last ()
	);

	assign busy = (state == ST_RUN);
	assign go   = (state == ST_IDLE) && start;
	assign fin  = (state == ST_RUN) && cur_last;

	always_comb begin
		next_op = go ? op : op_q;
		opa_src = go ? opcode_addr : opa_q;
		if (go) begin
			next_cycle = CYC_FETCH;
		end else if (state == ST_RUN && !cur_last) begin
			next_cycle = cycle + 4'h1;
		end else begin
			next_cycle = CYC_IDLE;
		end
		unique case (nxt_base)
			BASE_OPCODE: next_addr = opa_src + ext(nxt_off);
			BASE_STACK:  next_addr = sp_q + ext(nxt_off);
			BASE_VECTOR: next_addr = ADDR_VECTOR + ext(nxt_off);
			default:     next_addr = ADDR_DUMMY;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cycle <= CYC_IDLE;
		end else begin
			cycle <= next_cycle;
			if (go) begin
				state <= ST_RUN;
			end else if (fin) begin
				state <= ST_IDLE;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_q  <= OP_RETURN_SUB;
			opa_q <= 16'h0000;
			sp_q  <= 16'h0000;
		end else if (go) begin
			op_q  <= op;
			opa_q <= opcode_addr;
			sp_q  <= stack_ptr;
		end
	end

	// ----------------------------------------------------------------
	// Bus drive
	// ----------------------------------------------------------------
	// Registered so the bus never glitches between cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr       <= ADDR_DUMMY;
			rw         <= 1'b1;
			wr_data    <= 8'h00;
			bus_active <= 1'b0;
		end else begin
			addr       <= next_addr;
			rw         <= nxt_rw;
			wr_data    <= stack_byte(nxt_wsel);
			bus_active <= (next_cycle != CYC_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// Working registers and capture
	// ----------------------------------------------------------------
	// Dummy-read data is never captured; memory must tolerate those reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			res_pc <= 16'h0000;
			res_x  <= 16'h0000;
			res_a  <= 8'h00;
			res_b  <= 8'h00;
			res_cc <= 8'h00;
		end else if (go) begin
			res_pc <= opcode_addr + 16'h0001;
			res_x  <= index_in;
			res_a  <= acc_a_in;
			res_b  <= acc_b_in;
			res_cc <= ccr_in;
		end else if (state == ST_RUN && cur_rw) begin
			unique case (cur_rsel)
				BYTE_PCL: res_pc[7:0]  <= rd_data;
				BYTE_PCH: res_pc[15:8] <= rd_data;
				BYTE_XL:  res_x[7:0]   <= rd_data;
				BYTE_XH:  res_x[15:8]  <= rd_data;
				BYTE_A:   res_a        <= rd_data;
				BYTE_B:   res_b        <= rd_data;
				BYTE_CC:  res_cc       <= rd_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done   <= 1'b0;
			res_sp <= 16'h0000;
		end else begin
			done <= fin;
			if (fin) begin
				unique case (op_q)
					OP_RETURN_SUB:       res_sp <= sp_q + FRAME_RETURN;
					OP_INTERRUPT_RETURN: res_sp <= sp_q + FRAME_FULL;
					OP_MULTIPLY_8X8:     res_sp <= sp_q;
					default:             res_sp <= sp_q - FRAME_FULL;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_go(cbs_op_e o);
		go && op == o;
	endsequence

	sequence s_fetch_pair;
		rw && bus_active && addr == opa_q ##1
		rw && bus_active && addr == opa_q + 16'h0001;
	endsequence

	chk_return_sub_len: assert property (
		@(posedge clk) disable iff (rst)
		s_go(OP_RETURN_SUB) |=> s_fetch_pair ##1
		(rw && addr == sp_q) ##1 (rw && addr == sp_q + 16'h0001) ##1
		(rw && addr == sp_q + 16'h0002) ##1 done)
		else $error("subroutine return sequence wrong");

	chk_wait_shape: assert property (
		@(posedge clk) disable iff (rst)
		s_go(OP_WAIT_FOR_INTERRUPT) |=> s_fetch_pair ##1
		(!rw && bus_active)[*7] ##1 done)
		else $error("wait sequence wrong");

	chk_push_addr: assert property (
		@(posedge clk) disable iff (rst)
		(bus_active && !rw) |->
		addr == sp_q - 16'(cycle - CYC_STACK))
		else $error("stack write address wrong");

	chk_push_ccr: assert property (
		@(posedge clk) disable iff (rst)
		(bus_active && !rw && addr == sp_q - 16'h0006) |->
		wr_data == res_cc)
		else $error("condition codes not stacked last");

	chk_multiply_dummy: assert property (
		@(posedge clk) disable iff (rst)
		s_go(OP_MULTIPLY_8X8) |=> s_fetch_pair ##1
		(rw && addr == ADDR_DUMMY)[*8] ##1 done)
		else $error("multiply sequence wrong");

	chk_int_return_len: assert property (
		@(posedge clk) disable iff (rst)
		s_go(OP_INTERRUPT_RETURN) |=> s_fetch_pair ##1
		(rw && bus_active)[*8] ##1 done)
		else $error("interrupt return length wrong");
	chk_pull_addr: assert property (
		@(posedge clk) disable iff (rst)
		(bus_active && op_q == OP_INTERRUPT_RETURN && cycle >= CYC_STACK)
		|-> addr == sp_q + 16'(cycle - CYC_STACK))
		else $error("interrupt return pull address wrong");
	chk_soft_tail: assert property (
		@(posedge clk) disable iff (rst)
		s_go(OP_SOFTWARE_INTERRUPT) |=> ##9
		(rw && addr == sp_q - FRAME_FULL) ##1
		(rw && addr == ADDR_VECTOR) ##1
		(rw && addr == ADDR_VECTOR + 16'h0001) ##1 done)
		else $error("software interrupt tail wrong");
	chk_soft_vector: assert property (
		@(posedge clk) disable iff (rst)
		(done && op_q == OP_SOFTWARE_INTERRUPT) |->
		res_pc == {$past(rd_data, 2), $past(rd_data)})
		else $error("handler address not taken from vector");
	chk_sp_adjust: assert property (
		@(posedge clk) disable iff (rst)
		(done && (op_q == OP_SOFTWARE_INTERRUPT ||
		op_q == OP_WAIT_FOR_INTERRUPT)) |-> res_sp == sp_q - FRAME_FULL)
		else $error("stack pointer not lowered by frame");

	chk_sp_pull: assert property (
		@(posedge clk) disable iff (rst)
		(done && op_q == OP_RETURN_SUB) |-> res_sp == sp_q + FRAME_RETURN)
		else $error("stack pointer not raised after return");

endmodule

// ### tb/cbs_mem_model.sv
// Memory on the sequencer's system bus.
// Assumes reads answer in the same cycle and writes land at the clock edge.
`timescale 1ns/10ps

module cbs_mem_model (
	// Clock
	input  wire logic        clk,
	// Bus
	input  wire logic [15:0] addr,
	input  wire logic        rw,
	input  wire logic [7:0]  wr_data,
	input  wire logic        bus_active,
	output logic [7:0]       rd_data
);
	logic [7:0] mem [0:65535];
	logic [7:0] last;

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3c;
		end
		last = 8'h00;
	end

	always @(posedge clk) begin
		if (bus_active && !rw) begin
			mem[addr] <= wr_data;
		end
		if (bus_active) begin
			last <= rd_data;
		end
	end

	// Reads never alter contents, so dummy reads are harmless
	// Released bus shows the inverse so a stale byte cannot pass
	assign rd_data = bus_active ? mem[addr] : ~last;
endmodule

// ### tb/testbench.sv
// Self-checking bench for the bus cycle sequencer.
// Assumes cbs_pkg is compiled first and the memory model sits on the bus.
`timescale 1ns/10ps

module testbench
	import cbs_pkg::*;
;
	typedef struct {
		logic [15:0] pc, sp, x;
		logic [7:0]  a, b, cc;
		int          n;
	} cbs_tb_res_s;

	logic        clk, rst, start, rw, bus_active, busy, done;
	cbs_op_e     op;
	logic [15:0] opcode_addr, stack_ptr, index_in, addr, res_pc, res_sp, res_x;
	logic [7:0]  acc_a_in, acc_b_in, ccr_in, wr_data, rd_data;
	logic [7:0]  res_a, res_b, res_cc;
	logic [24:0] exp_bus[$];
	cbs_tb_res_s exp_res[$];
	logic [24:0] e;
	cbs_tb_res_s r;
	int          errors, samples_checked, cnt, seed;

	cbs_sequencer dut_u (.clk(clk), .rst(rst), .start(start), .op(op),
		.opcode_addr(opcode_addr), .stack_ptr(stack_ptr), .index_in(index_in),
		.acc_a_in(acc_a_in), .acc_b_in(acc_b_in), .ccr_in(ccr_in),
		.addr(addr), .rw(rw), .wr_data(wr_data), .bus_active(bus_active),
		.rd_data(rd_data), .busy(busy), .done(done), .res_pc(res_pc),
		.res_sp(res_sp), .res_x(res_x), .res_a(res_a), .res_b(res_b),
		.res_cc(res_cc));

	cbs_mem_model mem_u (.clk(clk), .addr(addr), .rw(rw), .wr_data(wr_data),
		.bus_active(bus_active), .rd_data(rd_data));

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		if (errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	function automatic logic [7:0] m(input logic [15:0] a);
		return mem_u.mem[a];
	endfunction

	task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
		exp_bus.push_back({a, w, d});
	endtask

	// ----------------------------------------------------------------
	// Driver: one instruction, optional ignored start while busy
	// ----------------------------------------------------------------
	task automatic run(input cbs_op_e o, input logic [15:0] oa, sp, x,
		input logic [7:0] a, b, cc, input bit junk);
		cbs_tb_res_s t;
		logic [7:0]  stk[7];
		int          i;
		op = o; opcode_addr = oa; stack_ptr = sp; index_in = x;
		acc_a_in = a; acc_b_in = b; ccr_in = cc; start = 1'b1;
		t = '{oa + 16'h1, sp, x, a, b, cc, 10};
		stk = '{t.pc[7:0], t.pc[15:8], x[7:0], x[15:8], a, b, cc};
		bus(oa, 1'b1, 8'h00);
		bus(oa + 16'h1, 1'b1, 8'h00);
		case (o)
			OP_RETURN_SUB: begin
				for (i = 0; i < 3; i++) bus(sp + 16'(i), 1'b1, 8'h00);
				t.pc = {m(sp + 16'h1), m(sp + 16'h2)};
				t.sp = sp + 16'h2;
				t.n = 5;
			end
			OP_MULTIPLY_8X8: begin
				for (i = 0; i < 8; i++) bus(16'hffff, 1'b1, 8'h00);
			end
			OP_INTERRUPT_RETURN: begin
				for (i = 0; i < 8; i++) bus(sp + 16'(i), 1'b1, 8'h00);
				t = '{{m(sp + 16'h6), m(sp + 16'h7)}, sp + 16'h7,
					{m(sp + 16'h4), m(sp + 16'h5)}, m(sp + 16'h3),
					m(sp + 16'h2), m(sp + 16'h1), 10};
			end
			default: begin
				for (i = 0; i < 7; i++) bus(sp - 16'(i), 1'b0, stk[i]);
				t.sp = sp - 16'h7;
				t.n = 9;
				if (o == OP_SOFTWARE_INTERRUPT) begin
					bus(sp - 16'h7, 1'b1, 8'h00);
					bus(16'hfffa, 1'b1, 8'h00);
					bus(16'hfffb, 1'b1, 8'h00);
					t.pc = {m(16'hfffa), m(16'hfffb)};
					t.n = 12;
				end
			end
		endcase
		exp_res.push_back(t);
		@(negedge clk);
		if (junk) begin
			op = cbs_op_e'(3'(($unsigned($random(seed))) % 5));
			opcode_addr = 16'($random(seed));
			stack_ptr = 16'($random(seed));
			@(negedge clk);
		end
		start = 1'b0;
		for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
		if (done !== 1'b1) begin
			check("done", done, 1'b1);
			summarize();
		end
	endtask

	// ----------------------------------------------------------------
	// Monitor
	// ----------------------------------------------------------------
	always @(negedge clk) begin
		if (!rst && bus_active === 1'b1) begin
			cnt++;
			check("busy", busy, 1'b1);
			if (exp_bus.size() == 0) begin
				check("bus_queue", exp_bus.size(), 1);
			end else begin
				e = exp_bus.pop_front();
				check("addr", addr, e[24:9]);
				check("rw", rw, e[8]);
				if (!e[8]) check("wr_data", wr_data, e[7:0]);
			end
		end
		if (!rst && done === 1'b1 && exp_res.size() > 0) begin
			r = exp_res.pop_front();
			check("cycles", cnt, r.n);
			check("res_pc", res_pc, r.pc);
			check("busy_done", busy, 1'b0);
			check("res_sp", res_sp, r.sp);
			check("res_x", res_x, r.x);
			check("res_acc", {res_a, res_b, res_cc}, {r.a, r.b, r.cc});
			cnt = 0;
		end
	end

	// ----------------------------------------------------------------
	// Clock and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		rst = 1'b1; start = 1'b0; op = OP_RETURN_SUB; opcode_addr = 16'h0000;
		stack_ptr = 16'h0000; index_in = 16'h0000; acc_a_in = 8'h00;
		acc_b_in = 8'h00; ccr_in = 8'h00; errors = 0; samples_checked = 0;
		cnt = 0; seed = 32'ha90a;
		repeat (20) @(negedge clk);
		check("idle", {addr, rw, bus_active, busy, done}, {16'hffff, 4'b1000});
		rst = 1'b0;
		@(negedge clk);
		for (int k = 0; k < 5; k++) begin
			run(cbs_op_e'(3'(k)), 16'h0400, 16'h1100, 16'hbeef, 8'h12, 8'h34,
				8'hd1, 1'b0);
		end
		// Stack a frame, then pull it back
		run(OP_SOFTWARE_INTERRUPT, 16'h0200, 16'h1080, 16'h5aa5, 8'h81,
			8'h7e, 8'hc3, 1'b1);
		run(OP_INTERRUPT_RETURN, 16'h3000, 16'h1079, 16'h0000, 8'h00, 8'h00,
			8'h00, 1'b0);
		check("restored_pc", res_pc, 16'h0201);
		check("restored_x", res_x, 16'h5aa5);
		for (int k = 0; k < 40; k++) begin
			run(cbs_op_e'(3'(($unsigned($random(seed))) % 5)), 16'($random(seed)),
				{4'h1, 12'($random(seed))}, 16'($random(seed)), 8'($random(seed)),
				8'($random(seed)), 8'($random(seed)), k[0]);
			if (k % 3 == 0) @(negedge clk);
		end
		repeat (3) @(negedge clk);
		check("left_over", exp_bus.size() + exp_res.size(), 0);
		summarize();
	end
endmodule
